// ---- core/nvmcc_pkg.sv ----
package nvmcc_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0]  OFF_CMD_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_CONTROL_TWO    = 8'h04;
  localparam int          CMD_LSB            = 0;
  localparam int          KEY_LSB            = 8;
  localparam logic [7:0]  EXECUTE_KEY_VALUE  = 8'ha5;
  localparam int          WAIT_LSB           = 1;
  localparam int          MANUAL_BIT         = 7;
  localparam int          SLEEP_LSB          = 8;
  localparam int          MISS_LSB           = 16;
  localparam int          CACHE_OFF_LSB      = 18;
  localparam logic [31:0] CONTROL_TWO_RESET  = 32'h0000_0080;
  localparam logic [31:0] CONTROL_TWO_MASK   = 32'h000f_039e;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [6:0] ERASE_MAIN_ROW     = 7'h02;
  localparam logic [6:0] WRITE_MAIN_PAGE    = 7'h04;
  localparam logic [6:0] ERASE_AUX_ROW      = 7'h05;
  localparam logic [6:0] WRITE_AUX_PAGE     = 7'h06;
  localparam logic [6:0] LOCK_REGION_CMD    = 7'h40;
  localparam logic [6:0] UNLOCK_REGION_CMD  = 7'h41;
  localparam logic [6:0] POWER_REDUCE_ON    = 7'h42;
  localparam logic [6:0] POWER_REDUCE_OFF   = 7'h43;
  localparam logic [6:0] BUFFER_CLEAR_CMD   = 7'h44;
  localparam logic [6:0] SECURITY_SET_CMD   = 7'h45;
  localparam logic [6:0] CACHE_FLUSH_CMD    = 7'h46;
  localparam logic [7:0] SECURITY_BYTE      = 8'h00;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [1:0] CACHE_MAIN_ONLY    = 2'h0;
  localparam logic [1:0] CACHE_NONE         = 2'h1;
  localparam logic [1:0] CACHE_BOTH         = 2'h2;
  localparam logic [1:0] FAST_MISS          = 2'h0;
  localparam logic [1:0] SLOW_MISS          = 2'h1;
  localparam logic [1:0] EVEN_TIMING        = 2'h2;
  localparam logic [1:0] WAKE_ON_FIRST_READ = 2'h0;
  localparam logic [1:0] WAKE_WITH_SLEEP_EXIT = 2'h1;
  localparam logic [1:0] SLEEP_SAVING_OFF   = 2'h3;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int          ADDR_W           = 22;
  localparam int          ROW_LSB          = 8;
  localparam logic [21:0] USER_ROW_ADDR    = 22'h20_0000;
  localparam logic [21:0] LOCKBIT_ROW_ADDR = 22'h20_2000;
  localparam int          REGION_LSB       = 14;
  localparam int          REGION_W         = 4;
  localparam int          LINE_LSB         = 3;
  localparam int          CACHE_IDX_W      = 4;
  localparam int          CACHE_TAG_W      = ADDR_W - LINE_LSB - CACHE_IDX_W + 1;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    NVMCC_IDLE = 2'b01,
    NVMCC_BUSY = 2'b10
  } nvmcc_state_t;

endpackage : nvmcc_pkg

// ---- core/nvmcc_wait_cnt.sv ----
`timescale 1ns/1ps

// Counts a loaded number of wait states, then pulses done
module nvmcc_wait_cnt #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // Result
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_reg;
  logic         active_reg;
  logic         done_reg;

  // Done comes value+1 cycles after load
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg    <= '0;
      active_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else if (load) begin
      cnt_reg    <= value;
      active_reg <= 1'b1;
      done_reg   <= 1'b0;
    end else begin
      done_reg   <= active_reg && (cnt_reg == '0);
      active_reg <= active_reg && (cnt_reg != '0);
      cnt_reg    <= (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    end
  end

  assign busy = active_reg;
  assign done = done_reg;

endmodule : nvmcc_wait_cnt

// ---- core/nvmcc_cache_tags.sv ----
`timescale 1ns/1ps

// Direct-mapped tag store; flush beats a fill in the same cycle
module nvmcc_cache_tags #(
  parameter int IDX_W = 4,
  parameter int TAG_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Lookup
  input  wire logic [IDX_W-1:0] idx,
  input  wire logic [TAG_W-1:0] tag,
  output logic                  hit,
  // Maintenance
  input  wire logic             fill,
  input  wire logic             flush
);

  logic [TAG_W-1:0]      tag_mem [2**IDX_W];
  logic [(2**IDX_W)-1:0] valid_reg;

  assign hit = valid_reg[idx] && (tag_mem[idx] == tag);

  // Valid bits only need reset; the tags follow
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_reg <= '0;
    end else if (flush) begin
      valid_reg <= '0;
    end else if (fill) begin
      valid_reg[idx] <= 1'b1;
    end
  end

  // Tag write on fill
  always_ff @(posedge clk) begin
    if (fill) begin
      tag_mem[idx] <= tag;
    end
  end

endmodule : nvmcc_cache_tags

// ---- core/nvmcc_core.sv ----
`timescale 1ns/1ps

module nvmcc_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register bus (APB)
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Held address and status
  input  wire logic [21:0] nvm_addr,
  input  wire logic        prog_error_clr,
  output logic             programming_error,
  output logic             cmd_ready,
  output logic             power_reduced,
  output logic             security_active,
  output logic      [15:0] region_locked,
  // Array operation port
  output logic             op_start,
  output logic      [6:0]  op_kind,
  output logic      [21:0] op_addr,
  output logic      [7:0]  op_wdata,
  input  wire logic        op_done,
  // Page buffer
  input  wire logic        pbuf_wr,
  input  wire logic        pbuf_last,
  input  wire logic        pbuf_aux,
  output logic             pbuf_clear,
  // Read port
  input  wire logic        rd_req,
  input  wire logic [21:0] rd_addr,
  input  wire logic        rd_rww,
  output logic             rd_busy,
  output logic             rd_done,
  output logic             rd_hit,
  // Power
  input  wire logic        sleep_active,
  output logic             nvm_low_power
);

  // ****************************************
  // Registers
  // ****************************************
  nvmcc_pkg::nvmcc_state_t state_reg;
  nvmcc_pkg::nvmcc_state_t state_next;
  logic [31:0] control_two_reg;
  logic [6:0]  last_cmd_reg;
  logic        key_pending_reg;
  logic [31:0] prdata_reg;
  logic        prog_err_reg;
  logic        prm_reg;
  logic        secure_reg;
  logic [15:0] lock_reg;
  logic        op_start_reg;
  logic [6:0]  op_kind_reg;
  logic [21:0] op_addr_reg;
  logic        pbuf_clear_reg;
  logic        sleep_d_reg;
  logic        sleep_lp_reg;
  logic        hit_reg;
  logic        fill_ok_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        wr_access    = psel && penable && pwrite;
  wire        rd_setup     = psel && !penable && !pwrite;
  wire        hit_cmd      = (paddr == nvmcc_pkg::OFF_CMD_CTRL);
  wire        hit_two      = (paddr == nvmcc_pkg::OFF_CONTROL_TWO);
  wire        addr_ok      = hit_cmd || hit_two;
  wire        cmd_wr       = wr_access && hit_cmd;
  wire        two_wr       = wr_access && hit_two;
  wire [6:0]  cmd_code     = pwdata[nvmcc_pkg::CMD_LSB +: 7];
  wire [7:0]  key_field    = pwdata[nvmcc_pkg::KEY_LSB +: 8];
  wire        key_ok       = (key_field == nvmcc_pkg::EXECUTE_KEY_VALUE);

  // Control-two fields
  wire        manual_page_write = control_two_reg[nvmcc_pkg::MANUAL_BIT];
  wire [3:0]  read_wait_count   = control_two_reg[nvmcc_pkg::WAIT_LSB +: 4];
  wire [1:0]  sleep_saving_sel  = control_two_reg[nvmcc_pkg::SLEEP_LSB +: 2];
  wire [1:0]  miss_timing_sel   = control_two_reg[nvmcc_pkg::MISS_LSB +: 2];
  wire [1:0]  cache_off_sel     = control_two_reg[nvmcc_pkg::CACHE_OFF_LSB +: 2];

  // ****************************************
  // Command decode
  // ****************************************
  wire is_er   = (cmd_code == nvmcc_pkg::ERASE_MAIN_ROW);
  wire is_wp   = (cmd_code == nvmcc_pkg::WRITE_MAIN_PAGE);
  wire is_ear  = (cmd_code == nvmcc_pkg::ERASE_AUX_ROW);
  wire is_wap  = (cmd_code == nvmcc_pkg::WRITE_AUX_PAGE);
  wire is_lr   = (cmd_code == nvmcc_pkg::LOCK_REGION_CMD);
  wire is_ur   = (cmd_code == nvmcc_pkg::UNLOCK_REGION_CMD);
  wire is_power_reduce_on = (cmd_code == nvmcc_pkg::POWER_REDUCE_ON);
  wire is_power_reduce_off = (cmd_code == nvmcc_pkg::POWER_REDUCE_OFF);
  wire is_pbc  = (cmd_code == nvmcc_pkg::BUFFER_CLEAR_CMD);
  wire is_ssb  = (cmd_code == nvmcc_pkg::SECURITY_SET_CMD);
  wire is_inv  = (cmd_code == nvmcc_pkg::CACHE_FLUSH_CMD);
  wire is_aux  = is_ear || is_wap;
  wire is_arr  = is_er || is_wp || is_aux || is_ssb;
  // Reserved codes are refused as a programming error
  wire known   = is_arr || is_lr || is_ur || is_power_reduce_on || is_power_reduce_off || is_pbc || is_inv;

  // Aux commands need security clear and the user row
  wire user_row = (nvm_addr[21:nvmcc_pkg::ROW_LSB] ==
                   nvmcc_pkg::USER_ROW_ADDR[21:nvmcc_pkg::ROW_LSB]);
  wire aux_ok   = !secure_reg && user_row;

  wire idle       = (state_reg == nvmcc_pkg::NVMCC_IDLE);
  wire cmd_accept = cmd_wr && key_ok && idle && known && (!is_aux || aux_ok);
  wire cmd_refuse = cmd_wr && !cmd_accept;

  // Automatic page write off the last buffer word
  wire auto_wp    = pbuf_wr && pbuf_last && !manual_page_write && idle && !cmd_accept;
  wire array_go   = (cmd_accept && is_arr) || auto_wp;

  wire [6:0] go_kind = auto_wp ? (pbuf_aux ? nvmcc_pkg::WRITE_AUX_PAGE
                                           : nvmcc_pkg::WRITE_MAIN_PAGE)
                               : cmd_code;
  // Security byte goes to the lock-bit row, others to the held address
  wire [21:0] go_addr = (!auto_wp && is_ssb) ? nvmcc_pkg::LOCKBIT_ROW_ADDR : nvmcc_pkg::ADDR_W'(nvm_addr);

  wire [nvmcc_pkg::REGION_W-1:0] region_idx =
    nvm_addr[nvmcc_pkg::REGION_LSB +: nvmcc_pkg::REGION_W];

  // Any content change invalidates the cache as well
  wire cache_flush = (cmd_accept && is_inv) || array_go;

  // ****************************************
  // Sequencer
  // ****************************************
  // Array commands hold the sequencer until the array reports done
  always_comb begin
    case (state_reg)
      nvmcc_pkg::NVMCC_IDLE: state_next = array_go ? nvmcc_pkg::NVMCC_BUSY
                                                   : nvmcc_pkg::NVMCC_IDLE;
      nvmcc_pkg::NVMCC_BUSY: state_next = op_done ? nvmcc_pkg::NVMCC_IDLE
                                                  : nvmcc_pkg::NVMCC_BUSY;
      default:               state_next = nvmcc_pkg::NVMCC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= nvmcc_pkg::NVMCC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Launch of an array operation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_start_reg <= 1'b0;
      op_kind_reg  <= '0;
      op_addr_reg  <= '0;
    end else begin
      op_start_reg <= array_go;
      if (array_go) begin
        op_kind_reg <= go_kind;
        op_addr_reg <= go_addr;
      end
    end
  end

  // ****************************************
  // Command side effects
  // ****************************************
  // Error flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_err_reg <= 1'b0;
    end else if (cmd_refuse) begin
      prog_err_reg <= 1'b1;
    end else if (prog_error_clr) begin
      prog_err_reg <= 1'b0;
    end
  end

  // Power reduction, lock bits, buffer clear and security
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prm_reg        <= 1'b0;
      lock_reg       <= '0;
      pbuf_clear_reg <= 1'b0;
      secure_reg     <= 1'b0;
    end else begin
      if (cmd_accept && is_power_reduce_on) prm_reg <= 1'b1;
      if (cmd_accept && is_power_reduce_off) prm_reg <= 1'b0;
      if (cmd_accept && is_lr) lock_reg[region_idx] <= 1'b1;
      if (cmd_accept && is_ur) lock_reg[region_idx] <= 1'b0;
      pbuf_clear_reg <= cmd_accept && is_pbc;
      // Only a chip erase clears security, which is outside this block
      if (!idle && op_done && op_kind_reg == nvmcc_pkg::SECURITY_SET_CMD)
        secure_reg <= 1'b1;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  // Reserved bits of control two are never stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_two_reg <= nvmcc_pkg::CONTROL_TWO_RESET;
      last_cmd_reg    <= '0;
      key_pending_reg <= 1'b0;
    end else begin
      if (two_wr) control_two_reg <= pwdata & nvmcc_pkg::CONTROL_TWO_MASK;
      if (cmd_wr) last_cmd_reg <= cmd_code;
      // Key bit 0 reads as one until the command is taken
      key_pending_reg <= cmd_wr ? !cmd_accept && key_field[0]
                                : key_pending_reg;
    end
  end

  wire [31:0] rd_mux = hit_cmd ? {16'h0000, 7'h00, key_pending_reg, 1'b0, last_cmd_reg}
                     : hit_two ? control_two_reg
                     : 32'h0000_0000;

  // Read data is captured in the setup phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= '0;
    end else if (rd_setup) begin
      prdata_reg <= rd_mux;
    end
  end

  // ****************************************
  // Read path and shared cache
  // ****************************************
  // Both sections share one tag store; the section bit joins the tag
  wire [nvmcc_pkg::CACHE_IDX_W-1:0] c_idx = rd_addr[nvmcc_pkg::LINE_LSB +: nvmcc_pkg::CACHE_IDX_W];
  wire [nvmcc_pkg::CACHE_TAG_W-1:0] c_tag = {rd_rww, rd_addr[21:nvmcc_pkg::LINE_LSB + nvmcc_pkg::CACHE_IDX_W]};
  logic tag_hit;
  logic wait_busy;
  logic wait_done;

  wire cacheable = rd_rww ? (cache_off_sel == nvmcc_pkg::CACHE_BOTH)
                          : (cache_off_sel == nvmcc_pkg::CACHE_MAIN_ONLY ||
                             cache_off_sel == nvmcc_pkg::CACHE_BOTH);
  wire rd_take   = rd_req && !wait_busy;
  wire look_hit  = tag_hit && cacheable;
  // Wait states per read, chosen by the miss timing mode
  wire [4:0] base_waits = {1'b0, read_wait_count};
  wire [4:0] waits = (!cacheable) ? base_waits
                   : (miss_timing_sel == nvmcc_pkg::EVEN_TIMING) ? base_waits
                   : look_hit ? 5'h00
                   : (miss_timing_sel == nvmcc_pkg::SLOW_MISS) ? 5'(base_waits + 5'h01)
                   : base_waits;

  nvmcc_cache_tags #(
    .IDX_W (nvmcc_pkg::CACHE_IDX_W),
    .TAG_W (nvmcc_pkg::CACHE_TAG_W)
  ) u_tags (
    .clk     (clk),
    .sys_rst (sys_rst),
    .idx     (c_idx),
    .tag     (c_tag),
    .hit     (tag_hit),
    .fill    (rd_take && cacheable && !tag_hit),
    .flush   (cache_flush)
  );

  nvmcc_wait_cnt #(
    .W (5)
  ) u_wait (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (rd_take),
    .value   (waits),
    .busy    (wait_busy),
    .done    (wait_done)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_reg     <= 1'b0;
      fill_ok_reg <= 1'b0;
    end else if (rd_take) begin
      hit_reg     <= look_hit;
      fill_ok_reg <= cacheable;
    end
  end

  // ****************************************
  // Sleep power reduction
  // ****************************************
  // Low power taken at sleep entry, left per the chosen wake policy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_d_reg  <= 1'b0;
      sleep_lp_reg <= 1'b0;
    end else begin
      sleep_d_reg <= sleep_active;
      if (sleep_active && !sleep_d_reg &&
          sleep_saving_sel != nvmcc_pkg::SLEEP_SAVING_OFF) begin
        sleep_lp_reg <= 1'b1;
      end else if (sleep_saving_sel == nvmcc_pkg::WAKE_ON_FIRST_READ && rd_req) begin
        sleep_lp_reg <= 1'b0;
      end else if (sleep_saving_sel == nvmcc_pkg::WAKE_WITH_SLEEP_EXIT && !sleep_active) begin
        sleep_lp_reg <= 1'b0;
      end else if (sleep_saving_sel == nvmcc_pkg::SLEEP_SAVING_OFF) begin
        sleep_lp_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata            = prdata_reg;
  assign pready            = 1'b1;
  assign pslverr           = psel && penable && !addr_ok;
  assign programming_error = prog_err_reg;
  assign cmd_ready         = idle;
  assign power_reduced     = prm_reg;
  assign security_active   = secure_reg;
  assign region_locked     = lock_reg;
  assign op_start          = op_start_reg;
  assign op_kind           = op_kind_reg;
  assign op_addr           = op_addr_reg;
  assign op_wdata          = nvmcc_pkg::SECURITY_BYTE;
  assign pbuf_clear        = pbuf_clear_reg;
  assign rd_busy           = wait_busy;
  assign rd_done           = wait_done;
  assign rd_hit            = hit_reg && fill_ok_reg;
  assign nvm_low_power     = prm_reg || sleep_lp_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_bad_key;
    cmd_wr && !key_ok;
  endsequence
  sequence s_arr_cmd;
    cmd_accept && is_arr;
  endsequence

  a_key_refused: assert property (s_bad_key |=> programming_error && !op_start)
    else $error("Wrong key did not flag an error");
  a_array_launch: assert property (s_arr_cmd |=> op_start && op_kind == $past(cmd_code) && !cmd_ready)
    else $error("Array command did not launch");
  a_aux_secure: assert property (cmd_wr && is_aux && secure_reg |=> !op_start ##0 programming_error)
    else $error("Aux command ran while secure");
  a_prm_toggle: assert property (cmd_accept && is_power_reduce_on |=> power_reduced && nvm_low_power)
    else $error("Power reduction not set");
  a_buffer_clear: assert property (cmd_accept && is_pbc |=> pbuf_clear ##1 !pbuf_clear)
    else $error("Buffer clear not a single pulse");
  a_lock_region: assert property (cmd_accept && is_lr |=> region_locked[$past(region_idx)])
    else $error("Region not locked");
  a_auto_write: assert property (auto_wp |=> op_start && (op_kind == nvmcc_pkg::WRITE_MAIN_PAGE || op_kind == nvmcc_pkg::WRITE_AUX_PAGE))
    else $error("Automatic page write missing");
  a_fast_zero: assert property (rd_take && waits == 5'h00 |=> rd_busy ##1 rd_done)
    else $error("Zero-wait read not done in two cycles");
  // Loaded count must be the programmed waits, hit or miss alike
  a_even_wait: assert property (rd_take && miss_timing_sel == nvmcc_pkg::EVEN_TIMING
    |=> u_wait.cnt_reg == {1'b0, $past(read_wait_count)})
    else $error("Even timing mode gave unequal waits");
  // Commanded reduction may still apply, only the sleep part is off
  a_sleep_off: assert property (sleep_saving_sel == nvmcc_pkg::SLEEP_SAVING_OFF
    |=> nvm_low_power == power_reduced)
    else $error("Low power entered with saving off");

endmodule : nvmcc_core

// ---- test/test_nvm_command_and_cache_control.sv ----
`timescale 1ns/1ps

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: mismatch", $time); end end

module test_nvm_command_and_cache_control;
  // ****
  // Bench signals
  // ****
  logic        clk, sys_rst, psel, penable, pwrite, err, prog_error_clr, op_done;
  logic        pbuf_wr, pbuf_last, pbuf_aux, rd_req, rd_rww, sleep_active;
  logic        pready, pslverr, programming_error, cmd_ready, power_reduced, security_active;
  logic        op_start, pbuf_clear, rd_busy, rd_done, rd_hit, nvm_low_power;
  logic [7:0]  paddr, op_wdata;
  logic [31:0] pwdata, prdata;
  logic [21:0] nvm_addr, rd_addr, op_addr;
  logic [15:0] region_locked;
  logic [6:0]  op_kind;
  logic [6:0]  ops [4] = '{7'h02, 7'h04, 7'h05, 7'h06};
  int          n_fail = 0, n_compared = 0, cyc = 0;

  nvmcc_core u_dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_addr(nvm_addr), .prog_error_clr(prog_error_clr),
    .programming_error(programming_error), .cmd_ready(cmd_ready),
    .power_reduced(power_reduced), .security_active(security_active),
    .region_locked(region_locked), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .op_wdata(op_wdata), .op_done(op_done), .pbuf_wr(pbuf_wr),
    .pbuf_last(pbuf_last), .pbuf_aux(pbuf_aux), .pbuf_clear(pbuf_clear), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_rww(rd_rww), .rd_busy(rd_busy), .rd_done(rd_done),
    .rd_hit(rd_hit), .sleep_active(sleep_active), .nvm_low_power(nvm_low_power)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Each task that drives signals waits an edge first, so no signal is set twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) #1;
    {psel, penable, pwrite, paddr, pwdata} = {2'b10, w, a, d};
    @(posedge clk) #1;
    penable = 1'b1;
    @(posedge clk);
    err = pslverr;
    #1;
    {psel, penable} = 2'b00;
  endtask : apb

  task cmd(input logic [6:0] c, input logic [7:0] k);
    apb(1'b1, 8'h00, {16'h0000, k, 1'b0, c});
  endtask : cmd

  task fin;
    @(posedge clk) #1;
    op_done = 1'b1;
    @(posedge clk) #1;
    op_done = 1'b0;
    `CHK(cmd_ready, 1'b1)
  endtask : fin

  task clr;
    @(posedge clk) #1;
    prog_error_clr = 1'b1;
    @(posedge clk) #1;
    prog_error_clr = 1'b0;
  endtask : clr

  // Counts the wait states between the take and the done pulse
  task rd(input logic [21:0] a, input logic s, input int w);
    int n;
    n = -1;
    @(posedge clk) #1;
    {rd_req, rd_addr, rd_rww} = {1'b1, a, s};
    @(posedge clk) #1;
    rd_req = 1'b0;
    `CHK(rd_busy, 1'b1)
    while (rd_done !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    `CHK(n, w)
  endtask : rd

  task test_done;
    $display("compared %0d, unexpected %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Hang guard, far above the roughly 170 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end

  // ****
  // Tests
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, prog_error_clr, op_done, err} = '0;
    {pbuf_wr, pbuf_last, pbuf_aux, rd_req, rd_addr, rd_rww, sleep_active} = '0;
    nvm_addr = nvmcc_pkg::USER_ROW_ADDR;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    `CHK({prdata, pready}, {32'h0000_0080, 1'b1})
    apb(1'b1, 8'h04, 32'hfffa_fdff);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(prdata, 32'h000a_019e)
    apb(1'b1, 8'h3c, 32'h1);
    `CHK(err, 1'b1)
    $display("registers done");
    cmd(7'h02, 8'h5a);
    `CHK({programming_error, op_start}, 2'b10)
    clr();
    `CHK(programming_error, 1'b0)
    for (int i = 0; i < 4; i++) begin
      cmd(ops[i], 8'ha5);
      `CHK({op_start, op_kind, op_addr, cmd_ready}, {1'b1, ops[i], nvm_addr, 1'b0})
      fin();
    end
    cmd(7'h45, 8'ha5);
    `CHK({op_start, op_kind, op_addr, op_wdata}, {1'b1, 7'h45, 22'h20_2000, 8'h00})
    fin();
    `CHK(security_active, 1'b1)
    cmd(7'h05, 8'ha5);
    `CHK({programming_error, op_start}, 2'b10)
    clr();
    nvm_addr = 22'h00_4000;
    cmd(7'h40, 8'ha5);
    `CHK(region_locked, 16'h0002)
    cmd(7'h41, 8'ha5);
    `CHK(region_locked, 16'h0000)
    cmd(7'h42, 8'ha5);
    `CHK(power_reduced, 1'b1)
    cmd(7'h43, 8'ha5);
    `CHK(power_reduced, 1'b0)
    cmd(7'h44, 8'ha5);
    `CHK(pbuf_clear, 1'b1)
    cmd(7'h03, 8'ha5);
    `CHK(programming_error, 1'b1)
    apb(1'b0, 8'h00, 32'h0);
    `CHK(prdata, 32'h0000_0103)
    apb(1'b1, 8'h04, 32'h0);
    pbuf_wr = 1'b1;
    pbuf_last = 1'b1;
    @(posedge clk) #1;
    {pbuf_wr, pbuf_last} = 2'b00;
    `CHK({op_start, op_kind}, {1'b1, 7'h04})
    fin();
    $display("commands done");
    apb(1'b1, 8'h04, 32'h84);
    rd(22'h100, 1'b0, 2);
    rd(22'h100, 1'b0, 0);
    `CHK(rd_hit, 1'b1)
    apb(1'b1, 8'h04, 32'h1_0084);
    rd(22'h200, 1'b0, 3);
    apb(1'b1, 8'h04, 32'h2_0084);
    rd(22'h100, 1'b0, 2);
    rd(22'h100, 1'b0, 2);
    apb(1'b1, 8'h04, 32'h84);
    rd(22'h300, 1'b1, 2);
    rd(22'h300, 1'b1, 2);
    apb(1'b1, 8'h04, 32'h8_0084);
    rd(22'h300, 1'b1, 2);
    rd(22'h300, 1'b1, 0);
    apb(1'b1, 8'h04, 32'h4_0084);
    rd(22'h300, 1'b1, 2);
    apb(1'b1, 8'h04, 32'h8_0084);
    cmd(7'h46, 8'ha5);
    rd(22'h300, 1'b1, 2);
    $display("reads done");
    sleep_active = 1'b1;
    @(posedge clk) #1;
    sleep_active = 1'b0;
    `CHK(nvm_low_power, 1'b1)
    @(posedge clk) #1;
    `CHK(nvm_low_power, 1'b1)
    rd(22'h300, 1'b1, 0);
    `CHK(nvm_low_power, 1'b0)
    apb(1'b1, 8'h04, 32'h8_0184);
    sleep_active = 1'b1;
    @(posedge clk) #1;
    `CHK(nvm_low_power, 1'b1)
    sleep_active = 1'b0;
    @(posedge clk) #1;
    `CHK(nvm_low_power, 1'b0)
    apb(1'b1, 8'h04, 32'h8_0384);
    sleep_active = 1'b1;
    @(posedge clk) #1;
    `CHK(nvm_low_power, 1'b0)
    $display("sleep done");
    test_done();
  end
endmodule : test_nvm_command_and_cache_control
